/* File: src/sodec_decoder.sv */
module sodec_decoder
  import sodec_pkg::*;
#(
  parameter bit TWO_AXES = 1'b1
)(
  input  wire logic                    clock,
  input  wire logic                    sys_rst,
  input  wire logic [IMAGE_BITS-1:0]   image,
  output sodec_axis_t                  axis1,
  output sodec_axis_t                  axis2,
  output logic                         axis2_torque_off,
  output logic                         diag_valid,
  output logic [15:0]                  diag_code,
  output logic                         diag_overrun
);
  // ----------------------------------------
  // Edge detection state
  // ----------------------------------------
  logic [2*DIAG_BITS-1:0] prev_diag;
  logic [2*DIAG_BITS-1:0] pending;
  logic [2*DIAG_BITS-1:0] now_diag;
  logic [2*DIAG_BITS-1:0] falls;
  logic [2*DIAG_BITS-1:0] next_pending;
  logic [2*DIAG_BITS-1:0] grant;
  logic [4:0]             grant_idx;
  logic                   any_pending;

  function automatic sodec_axis_t decode_axis(input logic en, input logic ack,
                                              input logic stage, input logic sup, input logic grp);
    decode_axis = '{path_enable: en, path_error_ack: ack, stage_enable: stage,
                    encoder_supply_ack: sup, group_fault: grp};
  endfunction

  // ----------------------------------------
  // Axis decode
  // ----------------------------------------
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      axis1 <= '0; // see RQ17
    end
    else
    begin
      // see RQ1 see RQ2 see RQ3 see RQ4 see RQ5 see RQ16 see RQ14
      axis1 <= decode_axis(image[POS_A_PATH_EN], image[POS_A_PATH_ACK], image[POS_A_STAGE_EN],
                           image[POS_A_SUPPLY_ACK], image[POS_A_GROUP]);
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst || !TWO_AXES)
    begin
      axis2 <= '0; // see RQ17
    end
    else
    begin
      // see RQ7 see RQ8 see RQ9 see RQ11 see RQ12
      axis2 <= decode_axis(image[POS_B_PATH_EN], image[POS_B_PATH_ACK], image[POS_B_STAGE_EN],
                           image[POS_B_SUPPLY_ACK], image[POS_B_GROUP]);
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst || !TWO_AXES)
    begin
      axis2_torque_off <= 1'b1; // see RQ17
    end
    else
    begin
      axis2_torque_off <= ~image[POS_B_STAGE_EN]; // see RQ10
    end
  end

  // ----------------------------------------
  // Diagnostic history feed
  // ----------------------------------------
  always_comb
  begin
    now_diag = {image[POS_B_DIAG +: DIAG_BITS], image[POS_A_DIAG +: DIAG_BITS]};
    if (!TWO_AXES)
    begin
      now_diag[2*DIAG_BITS-1:DIAG_BITS] = '1;
    end
    falls        = prev_diag & ~now_diag; // see RQ6 see RQ13
    any_pending  = |pending;
    grant        = pending & (~pending + 1'b1);
    grant_idx    = '0;
    for (int i = 0; i < 2*DIAG_BITS; i++)
    begin
      if (grant[i])
      begin
        grant_idx = 5'(i);
      end
    end
    next_pending = (pending & ~grant) | falls;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      prev_diag <= '1; // see RQ17
    end
    else
    begin
      prev_diag <= now_diag;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      pending <= '0;
    end
    else
    begin
      pending <= next_pending;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      diag_valid <= 1'b0;
    end
    else
    begin
      diag_valid <= any_pending;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      diag_code <= DIAG_RESET;
    end
    else
    begin
      diag_code <= any_pending ? DIAG_BASE_A + {11'h000, grant_idx} : DIAG_RESET; // see RQ6 see RQ13
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      diag_overrun <= 1'b0;
    end
    else
    begin
      diag_overrun <= |(pending & ~grant & falls);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_path1_follow: assert property (@(posedge clock) disable iff (sys_rst) // see RQ1
    1'b1 |=> axis1.path_enable == $past(image[POS_A_PATH_EN]))
    else $error("axis1 path enable mismatch");
  a_ack1_follow: assert property (@(posedge clock) disable iff (sys_rst) // see RQ2
    1'b1 |=> axis1.path_error_ack == $past(image[POS_A_PATH_ACK]))
    else $error("axis1 path ack mismatch");
  a_stage1_follow: assert property (@(posedge clock) disable iff (sys_rst) // see RQ3
    1'b1 |=> axis1.stage_enable == $past(image[POS_A_STAGE_EN]))
    else $error("axis1 stage mismatch");
  a_supply1_follow: assert property (@(posedge clock) disable iff (sys_rst) // see RQ4
    1'b1 |=> axis1.encoder_supply_ack == $past(image[POS_A_SUPPLY_ACK]))
    else $error("axis1 supply ack mismatch");
  a_group1_follow: assert property (@(posedge clock) disable iff (sys_rst) // see RQ5
    1'b1 |=> axis1.group_fault == $past(image[POS_A_GROUP]))
    else $error("axis1 group fault mismatch");
  a_diag_code_range: assert property (@(posedge clock) disable iff (sys_rst) // see RQ6
    diag_valid |-> diag_code >= DIAG_BASE_A && diag_code <= DIAG_BASE_B + 16'h000F)
    else $error("diag code out of range");
  a_fall_logged: assert property (@(posedge clock) disable iff (sys_rst) // see RQ6
    $fell(image[POS_A_DIAG]) && !$past(sys_rst) |=> ##[0:32] diag_valid && diag_code == DIAG_BASE_A)
    else $error("axis1 diag edge not logged");
  a_code_idle: assert property (@(posedge clock) disable iff (sys_rst) // see RQ6
    !diag_valid |-> diag_code == DIAG_RESET)
    else $error("diag code without valid");
  a_no_phantom: assert property (@(posedge clock) disable iff (sys_rst) // see RQ6
    !any_pending && falls == '0 |=> !diag_valid ##1 !diag_valid)
    else $error("diag code without falling edge");
  a_overrun_pending: assert property (@(posedge clock) disable iff (sys_rst) // see RQ6
    diag_overrun |-> diag_valid ##1 diag_valid)
    else $error("merged diag entry lost");
  a_fall2_logged: assert property (@(posedge clock) disable iff (sys_rst || !TWO_AXES) // see RQ13
    $fell(image[POS_B_DIAG]) && !$past(sys_rst) |=> ##[0:32] diag_valid && diag_code == DIAG_BASE_B)
    else $error("axis2 diag edge not logged");
  a_single_quiet: assert property (@(posedge clock) disable iff (sys_rst) // see RQ7
    !TWO_AXES |-> axis2 == '0 && axis2_torque_off)
    else $error("axis2 active in single axis mode");
  a_path2_follow: assert property (@(posedge clock) disable iff (sys_rst || !TWO_AXES) // see RQ8
    1'b1 |=> axis2.path_enable == $past(image[POS_B_PATH_EN]))
    else $error("axis2 path enable mismatch");
  a_stage2_follow: assert property (@(posedge clock) disable iff (sys_rst || !TWO_AXES) // see RQ10
    1'b1 |=> axis2.stage_enable == $past(image[POS_B_STAGE_EN]))
    else $error("axis2 stage mismatch");
  a_torque2_low: assert property (@(posedge clock) disable iff (sys_rst || !TWO_AXES) // see RQ10
    1'b1 |=> axis2_torque_off == !$past(image[POS_B_STAGE_EN]) && axis2.stage_enable == !axis2_torque_off)
    else $error("axis2 torque off wrong");
  a_ack2_follow: assert property (@(posedge clock) disable iff (sys_rst || !TWO_AXES) // see RQ9
    1'b1 |=> axis2.path_error_ack == $past(image[POS_B_PATH_ACK])
    && axis2.encoder_supply_ack == $past(image[POS_B_SUPPLY_ACK])
    && axis2.group_fault == $past(image[POS_B_GROUP]))
    else $error("axis2 ack or group mismatch");
  a_reset_safe: assert property (@(posedge clock) // see RQ17
    sys_rst |=> !axis1.path_enable && !axis1.stage_enable && axis2_torque_off && prev_diag == '1)
    else $error("reset state unsafe");
  a_reset_quiet: assert property (@(posedge clock) // see RQ17
    sys_rst |=> axis2 == '0 && !diag_valid && !diag_overrun && diag_code == DIAG_RESET)
    else $error("reset outputs not quiet");

  // ----------------------------------------
  // Coverage
  // ----------------------------------------
  c_diag_a: cover property (@(posedge clock) diag_valid && diag_code == DIAG_BASE_A);
  c_diag_b0: cover property (@(posedge clock) diag_valid && diag_code == DIAG_BASE_B);
  c_diag_b: cover property (@(posedge clock) diag_valid && diag_code == DIAG_BASE_B + 16'h000F);
  c_stage2_on: cover property (@(posedge clock) !axis2_torque_off);
  c_overrun: cover property (@(posedge clock) diag_overrun);
endmodule

/* File: src/sodec_pkg.sv */
// Functional notes
// RQ1 - Bit 0.0 enables axis-one switch-off path
// RQ2 - Bit 0.1 acknowledges axis-one path error
// RQ3 - Bit 0.2 enables axis-one output stage
// RQ4 - Bit 2.0 acknowledges axis-one encoder supply error
// RQ5 - Bit 4.0 forwarded as axis-one group fault
// RQ6 - Axis-one diag falling edge logs 0xD300+index
// RQ7 - Axis-two bits decode atop unchanged axis-one layout
// RQ8 - Bit 0.3 enables axis-two switch-off path
// RQ9 - Bit 0.4 acknowledges axis-two path error
// RQ10 - Bit 0.5 one drives axis-two torque-off low
// RQ11 - Bit 10.0 acknowledges axis-two encoder supply error
// RQ12 - Bit 12.0 forwarded as axis-two group fault
// RQ13 - Axis-two diag falling edge logs 0xD310+index
// RQ14 - Output image at most 32 bytes
// RQ15 - Writer avoids standard bits for safety shutdown
// RQ16 - Reserved command bytes 6 and 14 ignored
// RQ17 - Reset disables paths, diag history registers one
package sodec_pkg;
  // ----------------------------------------
  // Image layout
  // ----------------------------------------
  localparam int IMAGE_BYTES      = 32;
  localparam int IMAGE_BITS       = IMAGE_BYTES * 8;
  localparam int POS_A_PATH_EN    = 0;
  localparam int POS_A_PATH_ACK   = 1;
  localparam int POS_A_STAGE_EN   = 2;
  localparam int POS_B_PATH_EN    = 3;
  localparam int POS_B_PATH_ACK   = 4;
  localparam int POS_B_STAGE_EN   = 5;
  localparam int POS_A_SUPPLY_ACK = 2 * 8;
  localparam int POS_A_GROUP      = 4 * 8;
  localparam int POS_A_DIAG       = 8 * 8;
  localparam int POS_B_SUPPLY_ACK = 10 * 8;
  localparam int POS_B_GROUP      = 12 * 8;
  localparam int POS_B_DIAG       = 16 * 8;
  localparam int DIAG_BITS        = 16;
  // ----------------------------------------
  // Diagnostic codes
  // ----------------------------------------
  localparam logic [15:0] DIAG_BASE_A = 16'hD300;
  localparam logic [15:0] DIAG_BASE_B = 16'hD310;
  localparam logic [15:0] DIAG_RESET  = 16'h0000;

  typedef struct packed {
    logic path_enable;
    logic path_error_ack;
    logic stage_enable;
    logic encoder_supply_ack;
    logic group_fault;
  } sodec_axis_t;
endpackage

/* File: testbench/sodec_writer.sv */
module sodec_writer
  import sodec_pkg::*;
(
  input  wire logic [IMAGE_BITS-1:0] next_image,
  input  wire logic                  clock,
  output logic      [IMAGE_BITS-1:0] image
);
  timeunit 1ns;
  timeprecision 1ns;
  // Image write, standard bits not used for shutdown
  always_ff @(posedge clock)
  begin
    image <= next_image;
  end
endmodule

/* File: testbench/sodec_decoder_test.sv */
module sodec_decoder_test
  import sodec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [9:0]  sel;
    logic [7:0]  rsv;
    logic [10:0] exp;
  } sodec_row_t;
  logic                  clock;
  logic                  sys_rst;
  logic [IMAGE_BITS-1:0] next_image;
  logic [IMAGE_BITS-1:0] image;
  logic [IMAGE_BITS-1:0] img;
  sodec_axis_t           axis1;
  sodec_axis_t           axis2;
  logic                  axis2_torque_off;
  logic                  diag_valid;
  logic [15:0]           diag_code;
  logic                  diag_overrun;
  sodec_axis_t           axis1_s;
  sodec_axis_t           axis2_s;
  logic                  torque_off_s;
  logic                  valid_s;
  logic [15:0]           code_s;
  int                    fails;
  int                    n_compared;
  sodec_row_t            rows [12] = '{
    '{10'h001, 8'h00, 11'h401},
    '{10'h002, 8'h00, 11'h201},
    '{10'h004, 8'h00, 11'h101},
    '{10'h040, 8'h00, 11'h081},
    '{10'h080, 8'h00, 11'h041},
    '{10'h008, 8'h00, 11'h021},
    '{10'h010, 8'h00, 11'h011},
    '{10'h020, 8'h00, 11'h008},
    '{10'h100, 8'h00, 11'h005},
    '{10'h200, 8'h00, 11'h003},
    '{10'h000, 8'hff, 11'h001},
    '{10'h3ff, 8'hff, 11'h7fe}
  };
  initial clock = 1'b0;
  always #25 clock = ~clock;
  sodec_writer writer_u (.next_image(next_image), .clock(clock), .image(image));
  sodec_decoder #(.TWO_AXES(1'b1)) dut_u (.clock(clock), .sys_rst(sys_rst), .image(image),
    .axis1(axis1), .axis2(axis2), .axis2_torque_off(axis2_torque_off), .diag_valid(diag_valid),
    .diag_code(diag_code), .diag_overrun(diag_overrun));
  sodec_decoder #(.TWO_AXES(1'b0)) single_u (.clock(clock), .sys_rst(sys_rst), .image(image),
    .axis1(axis1_s), .axis2(axis2_s), .axis2_torque_off(torque_off_s), .diag_valid(valid_s),
    .diag_code(code_s), .diag_overrun());
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic collect(input int n, input logic [15:0] first, input int n_over, input int n_single);
    int k;
    int o;
    int s;
    k = 0;
    o = 0;
    s = 0;
    for (int c = 0; c < 60; c++)
    begin
      step(1);
      if (diag_valid === 1'b1)
      begin
        check(diag_code, first + 16'(k));
        k++;
      end
      if (valid_s === 1'b1)
      begin
        check(code_s, first + 16'(s));
        s++;
      end
      if (diag_overrun === 1'b1)
      begin
        o++;
      end
    end
    check(16'(k), 16'(n));
    check(16'(s), 16'(n_single));
    check(16'(o), 16'(n_over));
  endtask
  task automatic end_sim;
    $display("compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    fails = 0;
    n_compared = 0;
    sys_rst = 1'b1;
    next_image = '1;
    step(5);
    check(16'({axis1, axis2, axis2_torque_off}), 16'h0001);
    check(16'({axis1_s, axis2_s, torque_off_s}), 16'h0001);
    sys_rst = 1'b0;
    next_image = '0;
    collect(32, 16'hd300, 0, 16);
    $display("test reset and history done");
    foreach (rows[i])
    begin
      img = '0;
      img[5:0] = rows[i].sel[5:0];
      img[POS_A_SUPPLY_ACK] = rows[i].sel[6];
      img[POS_A_GROUP] = rows[i].sel[7];
      img[POS_B_SUPPLY_ACK] = rows[i].sel[8];
      img[POS_B_GROUP] = rows[i].sel[9];
      img[55:48] = rows[i].rsv;
      img[119:112] = rows[i].rsv;
      next_image = img;
      step(2);
      check(16'({axis1, axis2, axis2_torque_off}), 16'(rows[i].exp));
      check(16'({axis1_s, axis2_s, torque_off_s}), 16'({rows[i].exp[10:6], 6'h01}));
    end
    $display("test table done");
    img = '0;
    img[79] = 1'b1;
    img[128] = 1'b1;
    next_image = img;
    collect(0, 16'hd300, 0, 0);
    next_image = '0;
    collect(2, 16'hd30f, 0, 1);
    $display("test single falls done");
    next_image = '1;
    step(3);
    next_image = '0;
    step(1);
    img = '0;
    img[143] = 1'b1;
    next_image = img;
    step(1);
    next_image = '0;
    collect(32, 16'hd300, 1, 16);
    $display("test refall while pending done");
    next_image = '1;
    step(3);
    img = '1;
    img[POS_A_DIAG +: DIAG_BITS] = '0;
    img[POS_B_DIAG +: DIAG_BITS] = '0;
    next_image = img;
    step(2);
    sys_rst = 1'b1;
    step(2);
    check(16'({axis1, axis2, axis2_torque_off}), 16'h0001);
    check(16'({axis1_s, axis2_s, torque_off_s}), 16'h0001);
    check(16'({diag_valid, diag_overrun}), 16'h0000);
    sys_rst = 1'b0;
    collect(32, 16'hd300, 0, 16);
    $display("test mid-run reset done");
    end_sim();
  end
endmodule
